// ### shared/imr_regs.svh
// register map, field positions, reset values and timing counts
// assumes word index = byte address / 4 on a 32-bit bus
`ifndef IMR_REGS_SVH
`define IMR_REGS_SVH

// word indices (byte address is four times the index)
`define IMR_IDX_CTRL      8'h0D
`define IMR_IDX_ADDR_DATA 8'h0E
`define IMR_IDX_FLD_STAT  8'h0F
`define IMR_IDX_PHY_STAT  8'h10
`define IMR_IDX_RXERR_CNT 8'h15
`define IMR_IDX_TENBASE   8'h1A
`define IMR_IDX_IRQ_STAT  8'h20
`define IMR_IDX_IRQ_CLR   8'h21
`define IMR_IDX_IRQ_EN    8'h22
`define IMR_IDX_FLD_CTRL  8'h23

// control register fields
`define IMR_CMD_HI        15
`define IMR_CMD_LO        14
`define IMR_DEV_HI        4
`define IMR_DEV_LO        0
`define IMR_DEV_VENDOR    5'h1F
`define IMR_DEV_MMD3      5'h03
`define IMR_DEV_MMD7      5'h07
`define IMR_VENDOR_LIMIT  16'h04D1
`define IMR_ADDR_RESET    16'h000A

// link drop and phy status fields
`define IMR_FLD_STAT_LO   4
`define IMR_FLD_DESCR_EN  10
`define IMR_PHY_MDIX      14
`define IMR_PHY_RXERR     13
`define IMR_PHY_POL       12
`define IMR_TENBASE_POL   4

// receive error burst detection
`define IMR_RXERR_LIMIT   6'h20
`define IMR_RXERR_WIN_NS  10000
`define IMR_CLK_MHZ       50
`define IMR_RXERR_WIN_CYC ((`IMR_RXERR_WIN_NS * `IMR_CLK_MHZ) / 1000)

`endif

// ### shared/imr_pkg.sv
// types shared by the indirect access register bank
// assumes nothing beyond the register header
package imr_pkg;

  // indirect command field codes
  typedef enum logic [1:0] {
    IMR_CMD_ADDR    = 2'h0,
    IMR_CMD_DATA    = 2'h1,
    IMR_CMD_INC_RW  = 2'h2,
    IMR_CMD_INC_WR  = 2'h3
  } imr_cmd_e;

  // bus slave states, one-hot
  typedef enum logic [2:0] {
    IMR_ST_IDLE = 3'b001,
    IMR_ST_ACC  = 3'b010,
    IMR_ST_DONE = 3'b100
  } imr_state_e;

  // captured address phase
  typedef struct packed {
    logic [7:0] idx;
    logic       write;
  } imr_req_s;

  // detector inputs, one pulse per event
  typedef struct packed {
    logic descr_loss;
    logic rx_err;
    logic mlt3_trip;
    logic snr_trip;
    logic energy_loss;
  } imr_fld_evt_s;

endpackage

// ### core/imr_ext_mem.sv
// storage of the extended register spaces
// assumes one write port and one read port on the same clock
`timescale 1ns/1ps
module imr_ext_mem #(
  parameter int DW = 16,
  parameter int AW = 13
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // array has no reset to keep it mappable onto ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[raddr];
    end
  end

endmodule

// ### core/imr_top.sv
// indirect extended register access, link drop cause and phy status bank
// assumes an ahb-lite master with single word transfers; detector inputs
// are synchronous one-cycle pulses or levels on ref_clk
//
// Summary of operation
// - command 00 makes shared register the address, 01 data without increment
// - command 10 increments stored address after every data read or write
// - command 11 increments stored address only after data writes
// - device select bits 4:0 choose the space reached through shared register
// - select 11111 reaches vendor space, addresses up to 0x04D1
// - select 00011 reaches device 3, 00111 reaches device 7
// - any other select is ignored: nothing stored, zero returned
// - shared register is the address under command 00, else data there
// - cause field bits 8:4, one bit per cause: descrambler, rx err, mlt3, snr, energy
// - each cause bit latches when its enabled mode drops the link
// - status bit 14 shows pairs swapped by crossover logic
// - status bit 13 latches on receive error, cleared by counter read
// - status bit 12 mirrors polarity latch, cleared only by 10base read
// - link drop is or of five separately enabled conditions
// - receive error mode drops link at 32 errors within 10 us
`timescale 1ns/1ps
`include "imr_regs.svh"
module imr_top import imr_pkg::*; #(
  parameter int EXT_AW  = 11,
  parameter int RXE_WIN = `IMR_RXERR_WIN_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire imr_fld_evt_s fld_evt,
  input  wire logic         mdix_swapped,
  input  wire logic         pol_inverted,
  output logic              link_drop,
  output logic              irq
);

  localparam int MAW = EXT_AW + 2;

  ////////////////////////////////////////////////////////////////////////////
  // state

  imr_state_e    state_r, state_nxt;
  imr_req_s      req_r;
  imr_cmd_e      cmd_r;
  logic [4:0]    dev_r;
  logic [15:0]   addr_r [0:2];
  logic [4:0]    fld_cause_r;
  logic          rxerr_lh_r;
  logic          pol_lh_r;
  logic [4:0]    fld_en_r;
  logic [2:0]    irq_stat_r;
  logic [2:0]    irq_en_r;
  logic [5:0]    rxe_cnt_r;
  logic [15:0]   rxe_win_r;
  logic [15:0]   mem_rdata;

  // one word index per register; unmapped indices read zero
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    return a[9:2];
  endfunction

  // space number for a device select, 3 means unsupported
  function automatic logic [1:0] space_of(input logic [4:0] d);
    case (d)
      `IMR_DEV_VENDOR: return 2'h0;
      `IMR_DEV_MMD3:   return 2'h1;
      `IMR_DEV_MMD7:   return 2'h2;
      default:         return 2'h3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // hsize is not decoded: every access is taken as one whole word
  wire        take      = hsel && hready && htrans[1];
  wire        in_acc    = (state_r == IMR_ST_ACC);
  wire        wr_acc    = in_acc && req_r.write;
  wire        rd_acc    = in_acc && !req_r.write;
  wire        hit_ctrl  = (req_r.idx == `IMR_IDX_CTRL);
  wire        hit_ad    = (req_r.idx == `IMR_IDX_ADDR_DATA);
  wire        hit_fld   = (req_r.idx == `IMR_IDX_FLD_STAT);
  wire        hit_rxc   = (req_r.idx == `IMR_IDX_RXERR_CNT);
  wire        hit_tb    = (req_r.idx == `IMR_IDX_TENBASE);
  wire        hit_irqc  = (req_r.idx == `IMR_IDX_IRQ_CLR);
  wire        hit_irqe  = (req_r.idx == `IMR_IDX_IRQ_EN);
  wire        hit_fldc  = (req_r.idx == `IMR_IDX_FLD_CTRL);

  // selected space and its stored address
  wire [1:0]  space     = space_of(dev_r);
  wire        dev_ok    = (space != 2'h3);
  wire [15:0] cur_addr  = dev_ok ? addr_r[space] : 16'h0000;
  wire        addr_fits = (cur_addr >> EXT_AW) == 16'h0000;
  wire        vend_ok   = (space != 2'h0) || (cur_addr <= `IMR_VENDOR_LIMIT);
  wire        ext_ok    = dev_ok && addr_fits && vend_ok;
  wire        data_mode = (cmd_r != IMR_CMD_ADDR);

  // data accesses through the shared register
  wire        ad_wr     = wr_acc && hit_ad && dev_ok;
  wire        ad_rd     = rd_acc && hit_ad && dev_ok;
  wire        mem_we    = ad_wr && data_mode && ext_ok;
  wire        inc_rw    = (cmd_r == IMR_CMD_INC_RW) && (ad_wr || ad_rd);
  wire        inc_wo    = (cmd_r == IMR_CMD_INC_WR) && ad_wr;
  wire        post_inc  = data_mode && (inc_rw || inc_wo);
  wire [MAW-1:0] mem_a  = {space, cur_addr[EXT_AW-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  wire [15:0] ctrl_rd   = {cmd_r, 9'h000, dev_r};
  wire [15:0] ad_rd_val = !dev_ok    ? 16'h0000 :
                          !data_mode ? cur_addr :
                          ext_ok     ? mem_rdata : 16'h0000;
  wire [15:0] fld_rd    = {7'h00, fld_cause_r, 4'h0};
  wire [15:0] phy_rd    = {1'b0, mdix_swapped, rxerr_lh_r, pol_lh_r, 12'h000};
  wire [15:0] tb_rd     = {11'h000, pol_lh_r, 4'h0};
  wire [15:0] fldc_rd   = {5'h00, fld_en_r[4], 6'h00, fld_en_r[3:0]};
  logic [15:0] rd_val;

  // unmapped and write-only indices read as zero
  always_comb begin
    case (req_r.idx)
      `IMR_IDX_CTRL:      rd_val = ctrl_rd;
      `IMR_IDX_ADDR_DATA: rd_val = ad_rd_val;
      `IMR_IDX_FLD_STAT:  rd_val = fld_rd;
      `IMR_IDX_PHY_STAT:  rd_val = phy_rd;
      `IMR_IDX_TENBASE:   rd_val = tb_rd;
      `IMR_IDX_IRQ_STAT:  rd_val = {13'h0000, irq_stat_r};
      `IMR_IDX_IRQ_EN:    rd_val = {13'h0000, irq_en_r};
      `IMR_IDX_FLD_CTRL:  rd_val = fldc_rd;
      default:            rd_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave state machine: one wait state for every transfer, so read data can
  // come from the storage register and still leave hrdata on a flip-flop

  always_comb begin
    case (state_r)
      IMR_ST_IDLE: state_nxt = take ? IMR_ST_ACC : IMR_ST_IDLE;
      IMR_ST_ACC:  state_nxt = IMR_ST_DONE;
      IMR_ST_DONE: state_nxt = take ? IMR_ST_ACC : IMR_ST_IDLE;
      default:     state_nxt = IMR_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= IMR_ST_IDLE;
      req_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        req_r <= '{idx: word_idx(haddr), write: hwrite};
      end
    end
  end

  // bus outputs; hsize is always a word here, response is always okay
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= (state_nxt != IMR_ST_ACC);
      hresp     <= 1'b0;
      if (rd_acc) begin
        hrdata <= {16'h0000, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and enable registers

  // control word: reserved bits 13:5 are not stored, so they read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_r <= IMR_CMD_ADDR;
      dev_r <= 5'h00;
    end else if (wr_acc && hit_ctrl) begin
      cmd_r <= imr_cmd_e'(hwdata[`IMR_CMD_HI:`IMR_CMD_LO]);
      dev_r <= hwdata[`IMR_DEV_HI:`IMR_DEV_LO];
    end
  end

  // link drop enables: descrambler bit and the four counted modes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fld_en_r <= 5'h00;
    end else if (wr_acc && hit_fldc) begin
      fld_en_r <= {hwdata[`IMR_FLD_DESCR_EN], hwdata[3:0]};
    end
  end

  // interrupt enables
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_en_r <= 3'h0;
    end else if (wr_acc && hit_irqe) begin
      irq_en_r <= hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored extended address per space; loaded under command 00, advanced
  // by one at the end of the qualifying data access

  // only a supported select ever moves a pointer, so slot 3 is never written
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int s = 0; s < 3; s++) begin
        addr_r[s] <= `IMR_ADDR_RESET;
      end
    end else if (dev_ok) begin
      if (ad_wr && !data_mode) begin
        addr_r[space] <= hwdata[15:0];
      end else if (post_inc) begin
        addr_r[space] <= cur_addr + 16'h0001;
      end
    end
  end

  // read address follows the pointer so data is ready in the wait state
  imr_ext_mem #(
    .DW (16),
    .AW (MAW)
  ) i_imr_ext_mem (
    .clk     (ref_clk),
    .rstn    (rstn),
    .we      (mem_we),
    .waddr   (mem_a),
    .wdata   (hwdata[15:0]),
    .raddr   (mem_a),
    .rdata_r (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive error burst: count errors inside a fixed window, trip at limit
  // windows are fixed, not sliding, so a burst split by a window edge may not trip

  wire win_end  = (rxe_win_r == 16'(RXE_WIN - 1));
  wire rxe_trip = fld_evt.rx_err && (rxe_cnt_r == `IMR_RXERR_LIMIT - 6'h01);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxe_win_r <= 16'h0000;
      rxe_cnt_r <= 6'h00;
    end else begin
      rxe_win_r <= win_end ? 16'h0000 : rxe_win_r + 16'h0001;
      if (win_end || rxe_trip || !fld_en_r[3]) begin
        rxe_cnt_r <= 6'h00;
      end else if (fld_evt.rx_err) begin
        rxe_cnt_r <= rxe_cnt_r + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link drop causes, one bit per cause in field order

  wire [4:0] cause_hit = fld_en_r & {fld_evt.descr_loss, rxe_trip,
                                     fld_evt.mlt3_trip, fld_evt.snr_trip,
                                     fld_evt.energy_loss};
  wire       drop_now  = |cause_hit;
  wire       fld_rd_c  = rd_acc && hit_fld;
  wire       rxc_rd_c  = rd_acc && hit_rxc;
  wire       tb_rd_c   = rd_acc && hit_tb;

  // the drop strobe is registered so the output leaves a flip-flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      link_drop <= 1'b0;
    end else begin
      link_drop <= drop_now;
    end
  end

  // cause latches: a new event in the clearing cycle is kept, so a drop
  // that races the status read shows up on the next read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fld_cause_r <= 5'h00;
    end else begin
      fld_cause_r <= (fld_rd_c ? 5'h00 : fld_cause_r) | cause_hit;
    end
  end

  // receive error latch, cleared only by reading the error counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxerr_lh_r <= 1'b0;
    end else begin
      rxerr_lh_r <= (rxc_rd_c ? 1'b0 : rxerr_lh_r) | fld_evt.rx_err;
    end
  end

  // polarity latch is shared by both status views; only the 10base read
  // clears it, a phy status read leaves it alone
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pol_lh_r <= 1'b0;
    end else begin
      pol_lh_r <= (tb_rd_c ? 1'b0 : pol_lh_r) | pol_inverted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set beats clear

  wire [2:0] irq_set      = {pol_inverted, fld_evt.rx_err, drop_now};
  wire [2:0] irq_clr      = (wr_acc && hit_irqc) ? hwdata[2:0] : 3'h0;
  // set is or-ed in after the clear, so an event in the clearing cycle stays
  wire [2:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  // sticky status bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // irq follows the next status so it moves in step with the status bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_en_r);
    end
  end

endmodule

// ### testbench/imr_top_monitor.sv
// port-level checker for the indirect access register bank
// assumes binding onto imr_top; sees only its ports
`timescale 1ns/1ps
module imr_top_monitor import imr_pkg::*; #(
  parameter int EXT_AW  = 11,
  parameter int RXE_WIN = 500
) (
  input wire logic         ref_clk,
  input wire logic         rstn,
  input wire logic         hsel,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire imr_fld_evt_s fld_evt,
  input wire logic         link_drop
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // address phase accepted in this cycle
  wire logic take = hsel && hready && htrans[1];

  //////////////////////////////////////////////////////////////////////
  // bus timing: exactly one wait state, response always okay
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  wait_state_a: assert property (take |=> !hreadyout)
    else $error("no wait state after address phase");
  single_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  no_spur_wait_a: assert property (!hreadyout |-> $past(take))
    else $error("wait state without a transfer");
  // read data: upper half reserved, held between read completions
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside completion");
  write_keep_a: assert property (take && hwrite |=> ##1 $stable(hrdata))
    else $error("write disturbed read data");
  // a link drop always has a cause in the cycle before
  drop_cause_a: assert property (link_drop |-> $past(fld_evt) != 5'h00)
    else $error("link drop without cause");
endmodule

bind imr_top imr_top_monitor #(.EXT_AW(EXT_AW), .RXE_WIN(RXE_WIN)) i_imr_top_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fld_evt(fld_evt), .link_drop(link_drop));

// ### testbench/imr_top_bench.sv
// self-checking bench for the indirect access register bank
// assumes package and monitor compiled first; hready loops back from hreadyout
`timescale 1ns/1ps
module imr_top_bench import imr_pkg::*; ;
  localparam logic [7:0] CTL = 8'h34, AD = 8'h38, FS = 8'h3C, PS = 8'h40;
  localparam logic [7:0] EC = 8'h54, TB = 8'h68, IS = 8'h80, IC = 8'h84;
  localparam logic [7:0] IE = 8'h88, FE = 8'h8C;
  logic         ref_clk = 1'b0;
  logic         rstn    = 1'b0;
  logic         hsel    = 1'b0;
  logic         hwrite  = 1'b0;
  logic         mdix    = 1'b0;
  logic         pol     = 1'b0;
  logic         seen    = 1'b0;
  logic [1:0]   htrans  = 2'h0;
  logic [31:0]  haddr   = 32'h0;
  logic [31:0]  hwdata  = 32'h0;
  imr_fld_evt_s fld_evt = 5'h00;
  wire logic [31:0] hrdata;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic        link_drop;
  wire logic        irq;
  int bad_count = 0;
  int compares  = 0;

  // small window so the error burst fits in one run
  imr_top #(.RXE_WIN(80)) i_imr_top (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fld_evt(fld_evt),
    .mdix_swapped(mdix), .pol_inverted(pol), .link_drop(link_drop), .irq(irq));

  initial forever #10 ref_clk = ~ref_clk;

  // remember any link drop pulse since the flag was last cleared
  always @(posedge ref_clk) if (link_drop === 1'b1) seen = 1'b1;

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one single ahb-lite transfer; waits on hready, no fixed latency assumed
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] r;
    acc(1'b0, a, 16'h0, r);
    chk(r, {16'h0, e});
  endtask

  task automatic ct(input logic [1:0] c, input logic [4:0] s);
    wr(CTL, {c, 9'h0, s});
  endtask

  // hold a cause pattern for n cycles, then let the latches settle
  task automatic pulse(input logic [4:0] ev, input int n);
    @(posedge ref_clk);
    fld_evt <= ev;
    repeat (n) @(posedge ref_clk);
    fld_evt <= 5'h00;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(CTL, 16'h0000);
    rd(FS, 16'h0000);
    rd(8'hFC, 16'h0000);
    ct(2'h0, 5'h1F);
    rd(AD, 16'h000A);
    wr(CTL, 16'hFFFF);
    rd(CTL, 16'hC01F);
    $display("test reset done");
  endtask

  task automatic t_incr;
    ct(2'h0, 5'h1F);
    wr(AD, 16'h0100);
    ct(2'h2, 5'h1F);
    wr(AD, 16'hA1A1);
    wr(AD, 16'hA2A2);
    ct(2'h0, 5'h1F);
    rd(AD, 16'h0102);
    wr(AD, 16'h0100);
    ct(2'h2, 5'h1F);
    rd(AD, 16'hA1A1);
    rd(AD, 16'hA2A2);
    ct(2'h0, 5'h1F);
    wr(AD, 16'h0100);
    ct(2'h3, 5'h1F);
    rd(AD, 16'hA1A1);
    rd(AD, 16'hA1A1);
    wr(AD, 16'hC3C3);
    rd(AD, 16'hA2A2);
    ct(2'h1, 5'h1F);
    rd(AD, 16'hA2A2);
    ct(2'h0, 5'h1F);
    rd(AD, 16'h0101);
    $display("test incr done");
  endtask

  task automatic t_space;
    ct(2'h0, 5'h03);
    rd(AD, 16'h000A);
    wr(AD, 16'h0100);
    ct(2'h1, 5'h03);
    wr(AD, 16'hD3D3);
    ct(2'h0, 5'h07);
    wr(AD, 16'h0100);
    ct(2'h1, 5'h07);
    wr(AD, 16'hD7D7);
    rd(AD, 16'hD7D7);
    ct(2'h1, 5'h03);
    rd(AD, 16'hD3D3);
    ct(2'h0, 5'h1F);
    wr(AD, 16'h0100);
    ct(2'h1, 5'h1F);
    rd(AD, 16'hC3C3);
    ct(2'h1, 5'h05);
    wr(AD, 16'hFFFF);
    rd(AD, 16'h0000);
    ct(2'h0, 5'h1F);
    wr(AD, 16'h04D1);
    ct(2'h1, 5'h1F);
    wr(AD, 16'h5A5A);
    rd(AD, 16'h5A5A);
    ct(2'h0, 5'h1F);
    wr(AD, 16'h04D2);
    ct(2'h1, 5'h1F);
    wr(AD, 16'h1234);
    rd(AD, 16'h0000);
    $display("test space done");
  endtask

  // receive errors need a burst of 64 to fill one 80-cycle window with 32
  task automatic t_cause;
    wr(FE, 16'h040F);
    rd(FE, 16'h040F);
    for (int k = 0; k < 5; k++) begin
      seen = 1'b0;
      pulse(5'h10 >> k, (k == 1) ? 64 : 1);
      chk({31'h0, seen}, 32'h1);
      rd(FS, {7'h0, 5'h10 >> k, 4'h0});
      rd(FS, 16'h0000);
    end
    wr(FE, 16'h0000);
    seen = 1'b0;
    pulse(5'h10, 1);
    chk({31'h0, seen}, 32'h0);
    rd(FS, 16'h0000);
    $display("test cause done");
  endtask

  task automatic t_irq;
    wr(IC, 16'h0007);
    rd(IS, 16'h0000);
    wr(FE, 16'h0400);
    wr(IE, 16'h0001);
    pulse(5'h10, 1);
    rd(IS, 16'h0001);
    irq_is(1'b1);
    wr(IC, 16'h0001);
    irq_is(1'b0);
    wr(IE, 16'h0000);
    pulse(5'h10, 1);
    irq_is(1'b0);
    wr(FE, 16'h0000);
    $display("test irq done");
  endtask

  task automatic t_phy;
    @(posedge ref_clk);
    mdix    <= 1'b1;
    pol     <= 1'b1;
    fld_evt <= 5'h08;
    @(posedge ref_clk);
    pol     <= 1'b0;
    fld_evt <= 5'h00;
    rd(PS, 16'h7000);
    rd(PS, 16'h7000);
    rd(IS, 16'h0007);
    wr(IC, 16'h0006);
    rd(IS, 16'h0001);
    rd(EC, 16'h0000);
    rd(PS, 16'h5000);
    rd(TB, 16'h0010);
    rd(PS, 16'h4000);
    @(posedge ref_clk);
    mdix <= 1'b0;
    rd(PS, 16'h0000);
    $display("test phy done");
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_incr;
    t_space;
    t_cause;
    t_irq;
    t_phy;
    wrap_up;
  end

  // the tests need under a thousand cycles; this cuts a hang well beyond that
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule
